// ===== common/pmlhc_pkg.sv
// Package for the power mode and limp-home controller.
// Assumes a single system clock domain; pins are synchronised in the design.
package pmlhc_pkg;

	// ********************************************************************
	// Channel mode codes
	// ********************************************************************
	localparam logic [1:0] MODE_OFF_NODIAG = 2'h0;
	localparam logic [1:0] MODE_FOLLOW     = 2'h1;
	localparam logic [1:0] MODE_ON         = 2'h2;
	localparam logic [1:0] MODE_OFF_DIAG   = 2'h3;

	localparam int         NUM_CH          = 4;
	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam int         SYNC_STAGES     = 2;

	// ********************************************************************
	// Power modes, one-hot
	// ********************************************************************
	typedef enum logic [3:0] {
		PM_SLEEP = 4'b0001,
		PM_IDLE  = 4'b0010,
		PM_ON    = 4'b0100,
		PM_LIMP  = 4'b1000
	} pmlhc_mode_t;

	// ********************************************************************
	// Serial register write and transfer result
	// ********************************************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] modes;
	} pmlhc_wr_t;

	typedef struct packed {
		logic done;
		logic error;
	} pmlhc_xfer_t;

endpackage

// ===== src/pmlhc_ctrl.sv
// Power mode and limp-home control for a four channel low side driver.
// Assumes the serial frame decoder sits outside and hands over mode words
// and transfer-done pulses on CLK_SYS; the pins arrive asynchronously.
`timescale 1ns/1ns

// Notes on behaviour
// - Power-on reset gives defaults and idle.
// - Reset pin low forces register defaults.
// - Reset and failsafe low means sleep, clears.
// - Reset high, no clock activity: idle, off; code keeps on mode, and enters it on limp-home exit, without activity.
// - On mode drives enabled channels with diagnosis.
// - Failsafe request high with analog supply ok enters limp-home, clears registers.
// - In limp-home each input drives its output.
// - Limp-home ignores serial commands.
// - Failsafe request overrides reset, wakes from sleep.
// - Transfers during limp-home report transfer error.
// - On release clear, then sleep or on.
// - First transfer after limp-home reports error.
// - Four modes per channel via serial field.
// - A write of all channels off-no-diagnosis means idle mode.
// - Follow mode: input high on, low off.
// - Open input reads low, channel off.
module pmlhc_ctrl #(
	parameter int N_CH = 4
) (
	// Clock and power-on reset
	input  wire logic                      CLK_SYS,
	input  wire logic                      RESET,
	// Device pins
	input  wire logic                      RESET_N_PIN,
	input  wire logic                      FAILSAFE_REQUEST_PIN,
	input  wire logic                      ANALOG_SUPPLY_OK,
	input  wire logic                      SERIAL_CLOCK,
	input  wire logic [N_CH-1:0]           CONTROL_INPUT,
	// Serial register side
	input  wire pmlhc_pkg::pmlhc_wr_t      MODE_WRITE,
	input  wire logic                      TRANSFER_DONE,
	output logic                           TRANSFER_ERROR_FLAG,
	output logic [2*N_CH-1:0]              CHANNEL_MODE_FIELD,
	// Outputs
	output logic [N_CH-1:0]                CHANNEL_OUTPUT,
	output logic [N_CH-1:0]                DIAG_ACTIVE,
	output pmlhc_pkg::pmlhc_mode_t         POWER_MODE
);

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	// Open inputs are assumed pulled low by the pad, so they read as off.
	logic [N_CH+3:0] sync1_q;
	logic [N_CH+3:0] sync2_q;
	logic            sclk_prev_q;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			sclk_prev_q <= 1'b0;
		end else begin
			sync1_q     <= {CONTROL_INPUT, SERIAL_CLOCK, ANALOG_SUPPLY_OK,
				FAILSAFE_REQUEST_PIN, RESET_N_PIN};
			sync2_q     <= sync1_q;
			sclk_prev_q <= sync2_q[3];
		end
	end

	wire             rst_n_s   = sync2_q[0];
	wire             fs_req_s  = sync2_q[1];
	wire             avdd_ok_s = sync2_q[2];
	wire             sclk_s    = sync2_q[3];
	wire [N_CH-1:0]  inputs_s  = sync2_q[N_CH+3:4];
	wire             sclk_edge = sclk_s & ~sclk_prev_q;

	// ********************************************************************
	// Mode decision
	// ********************************************************************
	pmlhc_pkg::pmlhc_mode_t mode_q;
	pmlhc_pkg::pmlhc_mode_t mode_d;
	logic [2*N_CH-1:0]      field_q;
	logic                   ter_pend_q;
	logic                   ter_q;

	wire limp_req   = fs_req_s & avdd_ok_s;
	wire all_nodiag = (field_q == pmlhc_pkg::MODE_RESET);
	wire leave_limp = (mode_q == pmlhc_pkg::PM_LIMP) & ~limp_req;
	wire clear_regs = ~rst_n_s | limp_req | leave_limp;
	wire wr_ok      = MODE_WRITE.valid & ~clear_regs;

	always_comb begin
		case (mode_q)
			pmlhc_pkg::PM_SLEEP: begin
				if (limp_req) begin
					mode_d = pmlhc_pkg::PM_LIMP;
				end else if (rst_n_s) begin
					mode_d = pmlhc_pkg::PM_IDLE;
				end else begin
					mode_d = pmlhc_pkg::PM_SLEEP;
				end
			end
			pmlhc_pkg::PM_LIMP: begin
				if (limp_req) begin
					mode_d = pmlhc_pkg::PM_LIMP;
				end else if (!rst_n_s) begin
					mode_d = pmlhc_pkg::PM_SLEEP;
				end else begin
					mode_d = pmlhc_pkg::PM_ON;
				end
			end
			pmlhc_pkg::PM_IDLE, pmlhc_pkg::PM_ON: begin
				if (limp_req) begin
					mode_d = pmlhc_pkg::PM_LIMP;
				end else if (!rst_n_s) begin
					mode_d = pmlhc_pkg::PM_SLEEP;
				end else if (wr_ok && MODE_WRITE.modes == pmlhc_pkg::MODE_RESET) begin
					mode_d = pmlhc_pkg::PM_IDLE;
				end else if (wr_ok || sclk_edge) begin
					mode_d = pmlhc_pkg::PM_ON;
				end else if (mode_q == pmlhc_pkg::PM_ON && !all_nodiag) begin
					mode_d = pmlhc_pkg::PM_ON;
				end else if (mode_q == pmlhc_pkg::PM_ON) begin
					mode_d = pmlhc_pkg::PM_ON;  // Stays on until a write clears all.
				end else begin
					mode_d = pmlhc_pkg::PM_IDLE;
				end
			end
			default: begin
				mode_d = pmlhc_pkg::PM_IDLE;
			end
		endcase
	end

	// ********************************************************************
	// State and registers
	// ********************************************************************
	// Power-on reset lands in idle with default fields.
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			mode_q <= pmlhc_pkg::PM_IDLE;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			field_q <= pmlhc_pkg::MODE_RESET;
		end else if (clear_regs) begin
			field_q <= pmlhc_pkg::MODE_RESET;
		end else if (wr_ok) begin
			field_q <= MODE_WRITE.modes;
		end
	end

	// The pending error is armed on leaving limp-home; it is consumed by
	// the next completed transfer, and a new exit wins over that clear.
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ter_pend_q <= 1'b0;
		end else if (leave_limp) begin
			ter_pend_q <= 1'b1;
		end else if (TRANSFER_DONE) begin
			ter_pend_q <= 1'b0;
		end
	end

	wire ter_now = (mode_q == pmlhc_pkg::PM_LIMP) | ter_pend_q;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ter_q <= 1'b0;
		end else begin
			ter_q <= ter_now;
		end
	end

	// ********************************************************************
	// Channel drive
	// ********************************************************************
	logic [N_CH-1:0] out_d;
	logic [N_CH-1:0] diag_d;
	logic [N_CH-1:0] out_q;
	logic [N_CH-1:0] diag_q;

	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			out_d[i]  = 1'b0;
			diag_d[i] = 1'b0;
			if (mode_q == pmlhc_pkg::PM_LIMP) begin
				out_d[i] = inputs_s[i];
			end else if (mode_q == pmlhc_pkg::PM_ON) begin
				case (field_q[2*i +: 2])
					pmlhc_pkg::MODE_FOLLOW: begin
						out_d[i]  = inputs_s[i];
						diag_d[i] = 1'b1;
					end
					pmlhc_pkg::MODE_ON: begin
						out_d[i]  = 1'b1;
						diag_d[i] = 1'b1;
					end
					pmlhc_pkg::MODE_OFF_DIAG: begin
						diag_d[i] = 1'b1;
					end
					default: begin
						diag_d[i] = 1'b0;
					end
				endcase
				if (all_nodiag) begin
					diag_d[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			out_q  <= '0;
			diag_q <= '0;
		end else begin
			out_q  <= out_d;
			diag_q <= diag_d;
		end
	end

	assign CHANNEL_OUTPUT      = out_q;
	assign DIAG_ACTIVE         = diag_q;
	assign CHANNEL_MODE_FIELD  = field_q;
	assign TRANSFER_ERROR_FLAG = ter_q;
	assign POWER_MODE          = mode_q;

endmodule

// ===== sim/pmlhc_ctrl_monitor.sv
// Port checks for the mode controller.
// Assumes pins change only on the falling clock edge.
`timescale 1ns/1ns
module pmlhc_ctrl_monitor #(
	parameter int N_CH = 4
) (
	input wire logic                   CLK_SYS,
	input wire logic                   RESET,
	input wire logic                   RESET_N_PIN,
	input wire logic                   FAILSAFE_REQUEST_PIN,
	input wire logic                   ANALOG_SUPPLY_OK,
	input wire logic                   SERIAL_CLOCK,
	input wire logic [N_CH-1:0]        CONTROL_INPUT,
	input wire pmlhc_pkg::pmlhc_wr_t   MODE_WRITE,
	input wire logic                   TRANSFER_DONE,
	input wire logic                   TRANSFER_ERROR_FLAG,
	input wire logic [2*N_CH-1:0]      CHANNEL_MODE_FIELD,
	input wire logic [N_CH-1:0]        CHANNEL_OUTPUT,
	input wire logic [N_CH-1:0]        DIAG_ACTIVE,
	input wire pmlhc_pkg::pmlhc_mode_t POWER_MODE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Writes are only judged once the pins have settled in a live mode.
	sequence s_ready;
		(RESET_N_PIN && !FAILSAFE_REQUEST_PIN && (POWER_MODE[1] || POWER_MODE[2])) [*4];
	endsequence
	chk_limp_entry:
		assert property ((FAILSAFE_REQUEST_PIN && ANALOG_SUPPLY_OK) [*5] |-> POWER_MODE[3])
		else $error("no limp");
	chk_limp_route:
		assert property ((POWER_MODE[3] && $stable(CONTROL_INPUT)) [*5]
			|-> CHANNEL_OUTPUT == CONTROL_INPUT) else $error("bad limp route");
	chk_limp_error:
		assert property (POWER_MODE[3] [*2] |-> TRANSFER_ERROR_FLAG) else $error("no flag");
	chk_exit_error:
		assert property ($fell(POWER_MODE[3]) |-> ##2 TRANSFER_ERROR_FLAG [*3])
		else $error("no exit flag");
	chk_sleep_state:
		assert property ((!RESET_N_PIN && !FAILSAFE_REQUEST_PIN) [*6] |-> POWER_MODE[0]
			&& CHANNEL_OUTPUT == 4'h0 && CHANNEL_MODE_FIELD == 8'h00) else $error("no sleep");
	chk_write_field:
		assert property (s_ready ##0 MODE_WRITE.valid
			|=> CHANNEL_MODE_FIELD == $past(MODE_WRITE.modes)) else $error("bad field");
	chk_idle_write:
		assert property (s_ready ##0 MODE_WRITE.valid && MODE_WRITE.modes == 8'h00
			|=> POWER_MODE[1] ##1 DIAG_ACTIVE == 4'h0) else $error("no idle");
	chk_follow_input:
		assert property ((POWER_MODE[2] && CHANNEL_MODE_FIELD == 8'h55
			&& $stable(CONTROL_INPUT)) [*5] |-> CHANNEL_OUTPUT == CONTROL_INPUT)
		else $error("no follow");
endmodule
bind pmlhc_ctrl pmlhc_ctrl_monitor #(.N_CH(N_CH)) pmlhc_ctrl_monitor_inst (.*);

// ===== sim/pmlhc_host.sv
// Host model: serial clock bursts and end-of-transfer pulses.
// Assumes the bench calls frame at a falling system clock edge.
`timescale 1ns/1ns
module pmlhc_host (
	input wire logic CLK_SYS,
	output logic     SERIAL_CLOCK,
	output logic     TRANSFER_DONE
);
	initial begin
		SERIAL_CLOCK = 1'b0;
		TRANSFER_DONE = 1'b0;
	end
	// The clock rests low between frames, so idle detection sees no stray edge.
	task automatic frame;
		repeat (8) begin
			#400 SERIAL_CLOCK = 1'b1;
			#400 SERIAL_CLOCK = 1'b0;
		end
		@(negedge CLK_SYS) TRANSFER_DONE = 1'b1;
		@(negedge CLK_SYS) TRANSFER_DONE = 1'b0;
	endtask
endmodule

// ===== sim/pmlhc_ctrl_tb.sv
// Bench for the mode controller with a host model.
// Assumes four clock edges settle any pin change.
`timescale 1ns/1ns
module pmlhc_ctrl_tb;
	logic clk = 0, rst = 1, rst_n = 1, fs = 0, aok = 1, look = 0, sclk, done, err;
	logic [3:0] cin = 4'h0, outp, diag;
	logic [7:0] m, field;
	logic [11:0] q_st[$];
	logic q_fl[$];
	logic [31:0] rs = 32'h0000_6f55;
	pmlhc_pkg::pmlhc_wr_t wr = '0;
	pmlhc_pkg::pmlhc_mode_t pm;
	int fails = 0, n_compared = 0;
	always #50 clk = ~clk;
	pmlhc_host pmlhc_host_inst (.CLK_SYS(clk), .SERIAL_CLOCK(sclk), .TRANSFER_DONE(done));
	pmlhc_ctrl pmlhc_ctrl_inst (.CLK_SYS(clk), .RESET(rst), .RESET_N_PIN(rst_n),
		.FAILSAFE_REQUEST_PIN(fs), .ANALOG_SUPPLY_OK(aok), .SERIAL_CLOCK(sclk),
		.CONTROL_INPUT(cin), .MODE_WRITE(wr), .TRANSFER_DONE(done),
		.TRANSFER_ERROR_FLAG(err), .CHANNEL_MODE_FIELD(field), .CHANNEL_OUTPUT(outp),
		.DIAG_ACTIVE(diag), .POWER_MODE(pm));
	task automatic cmp(input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_st(input logic [11:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic complete_run;
		if (fails == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic expect_st(input logic [3:0] md, o, d);
		q_st.push_back({md, o, d});
		look = ~look;
	endtask
	task automatic frame(input logic e);
		q_fl.push_back(e);
		pmlhc_host_inst.frame();
	endtask
	task automatic write(input logic [7:0] v);
		wr = '{1'b1, v};
		tick(1);
		wr = '0;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [3:0] exp_out(input logic [7:0] v, input logic [3:0] in);
		for (int i = 0; i < 4; i++) begin
			exp_out[i] = v[2*i+:2] == pmlhc_pkg::MODE_ON
				|| (v[2*i+:2] == pmlhc_pkg::MODE_FOLLOW && in[i]);
		end
	endfunction
	function automatic logic [3:0] exp_diag(input logic [7:0] v);
		for (int i = 0; i < 4; i++) begin
			exp_diag[i] = v[2*i+:2] != pmlhc_pkg::MODE_OFF_NODIAG;
		end
	endfunction
	// Reading err before the edge's own update gives the response value.
	always @(posedge clk) begin
		if (done === 1'b1) cmp({7'h00, q_fl.pop_front()}, {7'h00, err});
	end
	always @(look) cmp_st(q_st.pop_front(), {pm, outp, diag});
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		complete_run;
	end
	initial begin
		tick(2);
		rst = 0;
		tick(5);
		expect_st(4'h2, 4'h0, 4'h0);
		frame(1'b0);
		for (int k = 0; k < 7; k++) begin
			rs = xs(rs);
			cin = rs[3:0];
			tick(4);
			m = (k == 0) ? 8'h55 : (k == 6) ? 8'h00 : rs[15:8];
			write(m);
			tick(3);
			expect_st(m == 8'h00 ? 4'h2 : 4'h4, exp_out(m, cin), exp_diag(m));
		end
		aok = 0;
		fs = 1;
		tick(6);
		expect_st(4'h2, 4'h0, 4'h0);
		fs = 0;
		aok = 1;
		tick(6);
		rst_n = 0;
		tick(6);
		expect_st(4'h1, 4'h0, 4'h0);
		fs = 1;
		tick(6);
		expect_st(4'h8, cin, 4'h0);
		fs = 0;
		tick(6);
		expect_st(4'h1, 4'h0, 4'h0);
		rst_n = 1;
		fs = 1;
		tick(6);
		write(8'haa);
		cin = ~cin;
		tick(5);
		expect_st(4'h8, cin, 4'h0);
		frame(1'b1);
		fs = 0;
		tick(6);
		expect_st(4'h4, 4'h0, 4'hf);
		frame(1'b1);
		frame(1'b0);
		complete_run;
	end
endmodule
